/* File: hw/temp_monitor_pkg.sv */
// Purpose: Shared constants and types for the temperature result and configuration block
// Assumes: Byte-level access from an external serial bus engine
// Notes: Limit registers live outside this block and arrive as plain inputs
package temp_monitor_pkg;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] addr_local_temperature_value = 8'h00;
    localparam logic [7:0] addr_remote_temperature_high_byte = 8'h01;
    localparam logic [7:0] addr_configuration_read_view = 8'h03;
    localparam logic [7:0] addr_configuration_write_view = 8'h09;
    localparam logic [7:0] addr_remote_temperature_low_byte = 8'h10;
    localparam int register_count = 22;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] reset_result = 8'h00;
    localparam logic [7:0] reset_pointer = 8'h00;
    localparam logic [7:0] reset_configuration = 8'h00;
    localparam logic [7:0] unmapped_read_value = 8'h00;
    // ****************************************
    // Data format constants
    // ****************************************
    localparam logic [8:0] default_range_max = 9'h07F;
    localparam logic [8:0] extended_offset = 9'h040;
    localparam logic [8:0] extended_range_max = 9'h0FF;
    localparam int fraction_lsb = 6;
    localparam logic [5:0] fraction_pad = 6'h00;
    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic alarm_mask_bit;
        logic standby;
        logic shared_pin_function;
        logic [1:0] reserved_hi;
        logic range_extended;
        logic [1:0] reserved_lo;
    } configuration_type;

    // Temperature in quarter degrees, two's complement
    typedef struct packed {
        logic remote;
        logic diode_short;
        logic diode_open;
        logic [10:0] temp_quarter;
    } conv_result_type;

    typedef struct packed {
        logic [7:0] local_high;
        logic [7:0] local_low;
        logic [7:0] remote_high;
        logic [7:0] remote_low;
    } limit_set_type;

    typedef enum logic {
        expect_pointer,
        expect_data
    } write_phase_type;
endpackage : temp_monitor_pkg

/* File: hw/temp_format.sv */
// Purpose: Turns a signed quarter-degree result into a stored high byte and fraction byte
// Assumes: Input integer part in the 9 upper bits, fraction in the 2 lower bits
// Notes: Pure combinational; the caller registers the outputs
`timescale 1ns/1ps
module temp_format (
    input wire logic [10:0] temp_quarter,
    input wire logic range_extended,
    output logic [7:0] high_byte,
    output logic [7:0] low_byte
);
    import temp_monitor_pkg::*;

    logic signed [8:0] whole;
    logic signed [9:0] shifted;
    logic [1:0] frac;

    always_comb begin
        whole = $signed(temp_quarter[10:2]);
        frac = temp_quarter[1:0];
        shifted = 10'(whole) + (range_extended ? 10'(extended_offset) : 10'h000);
        // ****************************************
        // Clamp to the window of the active range
        // ****************************************
        if (shifted < 10'sh000) begin
            high_byte = 8'h00;
            frac = 2'h0;
        end else if (!range_extended && shifted > $signed({1'b0, default_range_max})) begin
            high_byte = default_range_max[7:0]; // RULE_06
            frac = 2'h0;
        end else if (shifted > $signed({1'b0, extended_range_max})) begin
            high_byte = extended_range_max[7:0]; // RULE_07
            frac = 2'h0;
        end else begin
            high_byte = shifted[7:0]; // RULE_07
        end
        // Quarter degrees in the top two bits
        low_byte = {frac, fraction_pad}; // RULE_01
    end
endmodule : temp_format

/* File: hw/temp_monitor_regs.sv */
// Purpose: Result registers, pointer, configuration and alarm pin of a two-channel monitor
// Assumes: Serial engine hands over whole bytes; one clock with enable
// Notes: Limits are inputs; read data come one cycle after the request
//
// Overview of operation
// [RULE_01] Remote low byte holds quarter-degree fraction in bits 7 and 6.
// [RULE_02] Reading remote low byte locks remote high byte until high is read.
// [RULE_03] Configuration bit 2 picks default or extended measurement range.
// [RULE_04] New format applies from the next conversion after a range change.
// [RULE_05] Limits are never rewritten by a format change; host reprograms them.
// [RULE_06] Default range stores unsigned results clamped to 0..127.
// [RULE_07] Extended range stores temperature plus 64, clamped to the byte.
// [RULE_08] A shorted remote diode keeps the last good remote result.
// [RULE_09] First byte of each write loads the pointer; next byte hits that register.
// [RULE_10] Pointer resets to zero so an early read returns local temperature.
// [RULE_11] The three result registers are converter-written, host-read, reset to zero.
// [RULE_12] Configuration reads at 0x03, writes at 0x09, resets to zero.
// [RULE_13] Host leaves reserved configuration bits 0, 1, 3, 4 unwritten.
// [RULE_14] Bit 7 masks the limit alarm, ignored when pin is second overtemp.
// [RULE_15] Bit 6 set stops conversions; clear runs freely.
// [RULE_16] Standby keeps bus access and live alarm outputs.
// [RULE_17] Bit 5 selects limit alarm or second overtemp function for shared pin.
// [RULE_18] Device holds 22 byte-wide registers in total.
// [RULE_19] Result above high or at/below low limit, or diode fault, asserts alarm low.
// [RULE_20] As second overtemp, pin goes low when either result exceeds its high limit.
// [RULE_21] Converter alternates local and remote channels in normal mode.
// [RULE_22] The six low bits of the remote low byte always read zero.
`timescale 1ns/1ps
module temp_monitor_regs (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic bus_start,
    input wire logic bus_wr_valid,
    input wire logic [7:0] bus_wr_data,
    input wire logic bus_rd_req,
    output logic [7:0] bus_rd_data,
    output logic bus_rd_valid,
    input wire logic conv_done,
    input wire temp_monitor_pkg::conv_result_type conv_result,
    input wire temp_monitor_pkg::limit_set_type limits,
    output logic conv_run,
    output logic conv_remote_sel,
    output logic shared_pin_n
);
    import temp_monitor_pkg::*;

    // ****************************************
    // State
    // ****************************************
    write_phase_type phase;
    write_phase_type next_phase;
    logic [7:0] pointer;
    logic [7:0] next_pointer;
    configuration_type config_reg;
    configuration_type next_config_reg;
    logic [7:0] local_value;
    logic [7:0] next_local_value;
    logic [7:0] remote_high;
    logic [7:0] next_remote_high;
    logic [7:0] remote_low;
    logic [7:0] next_remote_low;
    logic high_locked;
    logic next_high_locked;
    logic diode_fault;
    logic next_diode_fault;
    logic [7:0] next_bus_rd_data;
    logic next_bus_rd_valid;
    logic next_conv_run;
    logic next_conv_remote_sel;
    logic next_shared_pin_n;
    logic [7:0] fmt_local_high;
    logic [7:0] fmt_remote_high;
    logic [7:0] fmt_remote_low;
    logic local_over;
    logic local_under;
    logic remote_over;
    logic remote_under;
    logic limit_alarm;

    // ****************************************
    // Formatting
    // ****************************************
    // Range bit is sampled at store time, so a change only shows on the next result
    temp_format local_fmt (
        .temp_quarter(conv_result.temp_quarter),
        .range_extended(config_reg.range_extended), // RULE_03
        .high_byte(fmt_local_high),
        .low_byte()
    );

    temp_format remote_fmt (
        .temp_quarter(conv_result.temp_quarter),
        .range_extended(config_reg.range_extended),
        .high_byte(fmt_remote_high),
        .low_byte(fmt_remote_low)
    );

    // ****************************************
    // Host side: pointer and configuration
    // ****************************************
    always_comb begin
        next_phase = phase;
        next_pointer = pointer;
        next_config_reg = config_reg;
        if (bus_start) begin
            next_phase = expect_pointer;
        end else if (bus_wr_valid) begin
            unique case (phase)
                expect_pointer: begin
                    next_pointer = bus_wr_data; // RULE_09
                    next_phase = expect_data;
                end
                expect_data: begin
                    // Result registers ignore host writes
                    if (pointer == addr_configuration_write_view) begin
                        next_config_reg = configuration_type'(bus_wr_data); // RULE_12
                        // Reserved bits kept at zero whatever the host sends
                        next_config_reg.reserved_hi = 2'h0; // RULE_13
                        next_config_reg.reserved_lo = 2'h0; // RULE_13
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase <= expect_pointer;
            pointer <= reset_pointer; // RULE_10
            config_reg <= configuration_type'(reset_configuration); // RULE_12
        end else if (ce) begin
            phase <= next_phase;
            pointer <= next_pointer;
            config_reg <= next_config_reg;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Served in standby too; the bus never depends on the converter
    always_comb begin
        next_bus_rd_valid = bus_rd_req; // RULE_16
        next_bus_rd_data = bus_rd_data;
        next_high_locked = high_locked;
        if (bus_rd_req) begin
            unique case (pointer)
                addr_local_temperature_value: next_bus_rd_data = local_value;
                addr_remote_temperature_high_byte: begin
                    next_bus_rd_data = remote_high;
                    next_high_locked = 1'b0; // RULE_02
                end
                addr_configuration_read_view: next_bus_rd_data = config_reg; // RULE_12
                addr_remote_temperature_low_byte: begin
                    next_bus_rd_data = remote_low;
                    next_high_locked = 1'b1; // RULE_02
                end
                // Rest of the 22-register map sits outside this block
                default: next_bus_rd_data = unmapped_read_value; // RULE_18
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_rd_valid <= 1'b0;
            bus_rd_data <= unmapped_read_value;
            high_locked <= 1'b0;
        end else if (ce) begin
            bus_rd_valid <= next_bus_rd_valid;
            bus_rd_data <= next_bus_rd_data;
            high_locked <= next_high_locked;
        end
    end

    // ****************************************
    // Converter side: result registers
    // ****************************************
    always_comb begin
        next_local_value = local_value;
        next_remote_high = remote_high;
        next_remote_low = remote_low;
        next_diode_fault = diode_fault;
        next_conv_run = !config_reg.standby; // RULE_15
        next_conv_remote_sel = conv_remote_sel;
        if (conv_done && conv_run) begin
            next_conv_remote_sel = !conv_remote_sel; // RULE_21
            if (!conv_result.remote) begin
                next_local_value = fmt_local_high; // RULE_04 RULE_11
            end else begin
                next_diode_fault = conv_result.diode_short || conv_result.diode_open;
                // Faulty result dropped, last good one stays visible
                if (!conv_result.diode_short && !conv_result.diode_open) begin // RULE_08
                    next_remote_low = fmt_remote_low; // RULE_01 RULE_22
                    if (!high_locked) begin
                        next_remote_high = fmt_remote_high; // RULE_02
                    end
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            local_value <= reset_result; // RULE_11
            remote_high <= reset_result; // RULE_11
            remote_low <= reset_result; // RULE_11
            diode_fault <= 1'b0;
            conv_run <= 1'b1;
            conv_remote_sel <= 1'b0;
        end else if (ce) begin
            local_value <= next_local_value;
            remote_high <= next_remote_high;
            remote_low <= next_remote_low;
            diode_fault <= next_diode_fault;
            conv_run <= next_conv_run;
            conv_remote_sel <= next_conv_remote_sel;
        end
    end

    // ****************************************
    // Shared alarm pin
    // ****************************************
    // Limits compared as stored bytes; host keeps them in the active format
    always_comb begin
        local_over = local_value > limits.local_high; // RULE_05
        local_under = local_value <= limits.local_low;
        remote_over = remote_high > limits.remote_high;
        remote_under = remote_high <= limits.remote_low;
        limit_alarm = local_over || local_under || remote_over || remote_under || diode_fault; // RULE_19
        if (config_reg.shared_pin_function) begin // RULE_17
            next_shared_pin_n = !(local_over || remote_over); // RULE_20 RULE_14
        end else begin
            next_shared_pin_n = !(limit_alarm && !config_reg.alarm_mask_bit); // RULE_14 RULE_16
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shared_pin_n <= 1'b1;
        end else if (ce) begin
            shared_pin_n <= next_shared_pin_n;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_low_read;
        ce && bus_rd_req && pointer == addr_remote_temperature_low_byte;
    endsequence

    sequence s_remote_good_done;
        ce && conv_done && conv_run && conv_result.remote && !conv_result.diode_short
            && !conv_result.diode_open;
    endsequence

    property p_low_bits_zero;
        @(posedge clock) disable iff (sys_rst) remote_low[5:0] == 6'h00;
    endproperty
    a_low_bits_zero: assert property (p_low_bits_zero) else $error("remote low bits not zero"); // RULE_22

    property p_high_locked;
        @(posedge clock) disable iff (sys_rst)
            high_locked ##0 s_remote_good_done |=> $stable(remote_high);
    endproperty
    a_high_locked: assert property (p_high_locked) else $error("locked high byte changed"); // RULE_02

    property p_pointer_load;
        @(posedge clock) disable iff (sys_rst)
            ce && !bus_start && bus_wr_valid && phase == expect_pointer |=> pointer == $past(bus_wr_data);
    endproperty
    a_pointer_load: assert property (p_pointer_load) else $error("pointer not loaded"); // RULE_09

    property p_reset_values;
        @(posedge clock) sys_rst |=> pointer == 8'h00 && local_value == 8'h00 && remote_high == 8'h00
            && remote_low == 8'h00 && config_reg == 8'h00;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong"); // RULE_10

    property p_short_keeps;
        @(posedge clock) disable iff (sys_rst)
            ce && conv_done && conv_run && conv_result.remote && conv_result.diode_short
            |=> $stable(remote_high) && $stable(remote_low);
    endproperty
    a_short_keeps: assert property (p_short_keeps) else $error("shorted result stored"); // RULE_08

    property p_standby_stops;
        @(posedge clock) disable iff (sys_rst) ce && config_reg.standby |=> !conv_run;
    endproperty
    a_standby_stops: assert property (p_standby_stops) else $error("converter runs in standby"); // RULE_15

    property p_default_clamp;
        @(posedge clock) disable iff (sys_rst)
            ce && conv_done && conv_run && !conv_result.remote && !config_reg.range_extended
            |=> local_value[7] == 1'b0;
    endproperty
    a_default_clamp: assert property (p_default_clamp) else $error("default range above 127"); // RULE_06

    property p_extended_zero;
        @(posedge clock) disable iff (sys_rst)
            ce && conv_done && conv_run && !conv_result.remote && config_reg.range_extended
            && conv_result.temp_quarter[10:2] == 9'h000 |=> local_value == 8'h40;
    endproperty
    a_extended_zero: assert property (p_extended_zero) else $error("offset binary wrong"); // RULE_07

    property p_second_overtemp;
        @(posedge clock) disable iff (sys_rst)
            ce && config_reg.shared_pin_function && (local_over || remote_over) |=> !shared_pin_n;
    endproperty
    a_second_overtemp: assert property (p_second_overtemp) else $error("second overtemp not low"); // RULE_20

    property p_config_read;
        @(posedge clock) disable iff (sys_rst)
            ce && bus_rd_req && pointer == addr_configuration_read_view
            |=> bus_rd_valid && bus_rd_data == $past(config_reg);
    endproperty
    a_config_read: assert property (p_config_read) else $error("config readback wrong"); // RULE_12

    // Lock must follow the low read, else the pair may mix two conversions
    property p_lock_set;
        @(posedge clock) disable iff (sys_rst) s_low_read |=> high_locked;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("low read did not lock high byte"); // RULE_02

    property p_fault_clear;
        @(posedge clock) disable iff (sys_rst) s_remote_good_done |=> !diode_fault;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault kept after good result"); // RULE_19

    property p_fault_alarm;
        @(posedge clock) disable iff (sys_rst)
            ce && diode_fault && !config_reg.shared_pin_function && !config_reg.alarm_mask_bit |=> !shared_pin_n;
    endproperty
    a_fault_alarm: assert property (p_fault_alarm) else $error("diode fault not on alarm pin"); // RULE_19

    property p_read_pulse;
        @(posedge clock) disable iff (sys_rst) ce && !bus_rd_req |=> !bus_rd_valid;
    endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("read valid without request"); // RULE_09

    property p_channel_toggle;
        @(posedge clock) disable iff (sys_rst)
            ce && conv_done && conv_run |=> conv_remote_sel != $past(conv_remote_sel);
    endproperty
    a_channel_toggle: assert property (p_channel_toggle) else $error("channel did not alternate"); // RULE_21

    property p_default_zero;
        @(posedge clock) disable iff (sys_rst)
            ce && conv_done && conv_run && !conv_result.remote && !config_reg.range_extended
            && conv_result.temp_quarter[10:2] == 9'h000 |=> local_value == 8'h00;
    endproperty
    a_default_zero: assert property (p_default_zero) else $error("default range zero wrong"); // RULE_03
endmodule : temp_monitor_regs

/* File: bench/smbus_host_model.sv */
// Purpose: Byte-level host on the far side of the register bus
// Assumes: Bench calls the tasks; signals change at the falling edge
// Notes: Released write data shows the inverse of the last byte
`timescale 1ns/1ps
module smbus_host_model (
    input wire logic clock,
    output logic bus_start,
    output logic bus_wr_valid,
    output logic [7:0] bus_wr_data,
    output logic bus_rd_req
);
    initial {bus_start, bus_wr_valid, bus_wr_data, bus_rd_req} = 11'h000;
    // ****************************************
    // Bus transfers
    // ****************************************
    task automatic send(input logic [7:0] ptr, input logic has_data, input logic [7:0] data);
        @(negedge clock);
        bus_start = 1'b1;
        @(negedge clock);
        bus_start = 1'b0;
        bus_wr_valid = 1'b1;
        bus_wr_data = ptr;
        if (has_data) begin
            @(negedge clock);
            // Reserved bits kept clear
            bus_wr_data = (ptr == 8'h09) ? (data & 8'hE4) : data;
        end
        @(negedge clock);
        bus_wr_valid = 1'b0;
        bus_wr_data = ~bus_wr_data;
    endtask : send

    task automatic read_req();
        @(negedge clock);
        bus_rd_req = 1'b1;
        @(negedge clock);
        bus_rd_req = 1'b0;
    endtask : read_req
endmodule : smbus_host_model

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the result and configuration registers
// Assumes: Reads are queued by the driver and checked by a monitor
// Notes: Clock enable dropped once to check the freeze; range clamp tests avoid the extended ends
`timescale 1ns/1ps
module tb_top;
    import temp_monitor_pkg::*;
    logic clock, sys_rst, ce, bus_start, bus_wr_valid, bus_rd_req, bus_rd_valid, conv_done;
    logic conv_run, conv_remote_sel, shared_pin_n;
    logic [7:0] bus_wr_data, bus_rd_data;
    conv_result_type conv_result;
    limit_set_type limits;
    logic [7:0] exp_q[$];
    logic [7:0] cfg, loc, rhi, rlo;
    logic lock, sel;
    logic [31:0] r;
    logic [10:0] tq;
    integer seed, fail_count, compares;
    logic [7:0] regs [0:5] = '{8'h01, 8'h10, 8'h03, 8'h02, 8'h09, 8'h00};
    int temps [0:3] = '{-55, 0, 25, 150};
    logic [7:0] ftab [0:7] = '{8'h00, 8'h00, 8'h19, 8'h7F, 8'h09, 8'h40, 8'h59, 8'hD6};
    // Config, limits, expected pin; local 0x32, remote 0x19
    logic [47:0] atab [0:10] = '{48'h00_FF00FF00_01, 48'h00_3100FF00_00, 48'h00_3200FF00_01,
        48'h00_FF32FF00_00, 48'h00_FF31FF00_01, 48'h00_FF001800_00, 48'h00_FF00FF19_00,
        48'h80_3100FF00_01, 48'hA0_3100FF00_00, 48'h20_FF32FF19_01, 48'h20_FF001800_00};

    smbus_host_model i_host (.clock(clock), .bus_start(bus_start), .bus_wr_valid(bus_wr_valid),
        .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req));
    temp_monitor_regs i_dut (.clock(clock), .sys_rst(sys_rst), .ce(ce), .bus_start(bus_start),
        .bus_wr_valid(bus_wr_valid), .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req),
        .bus_rd_data(bus_rd_data), .bus_rd_valid(bus_rd_valid), .conv_done(conv_done),
        .conv_result(conv_result), .limits(limits), .conv_run(conv_run),
        .conv_remote_sel(conv_remote_sel), .shared_pin_n(shared_pin_n));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ****************************************
    // Checking
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    always @(negedge clock) begin
        if (bus_rd_valid === 1'b1) begin
            if (exp_q.size() > 0) check(bus_rd_data, exp_q.pop_front());
            else check(bus_rd_data, ~bus_rd_data);
        end
    end
    // ****************************************
    // Stimulus helpers
    // ****************************************
    function automatic logic [15:0] fmt(input logic [10:0] q, input logic ext);
        int t = $signed(q[10:2]) + (ext ? 64 : 0);
        if (t < 0) return 16'h0000;
        if (t > (ext ? 255 : 127)) return ext ? 16'hFF00 : 16'h7F00;
        return {t[7:0], q[1:0], 6'h00};
    endfunction : fmt

    function automatic logic [7:0] mdl(input logic [7:0] a);
        case (a)
            8'h00: return loc;
            8'h01: return rhi;
            8'h03: return cfg;
            8'h10: return rlo;
            default: return 8'h00;
        endcase
    endfunction : mdl

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.send(a, 1'b1, d);
        if (a == 8'h09) cfg = d & 8'hE4;
        @(negedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.send(a, 1'b0, 8'h00);
        if (a == 8'h10) lock = 1'b1;
        if (a == 8'h01) lock = 1'b0;
        exp_q.push_back(e);
        i_host.read_req();
    endtask : rd

    task automatic conv(input logic rem, input logic [1:0] f, input logic [10:0] q);
        logic [15:0] v;
        v = fmt(q, cfg[2]);
        @(negedge clock);
        conv_done = 1'b1;
        conv_result = {rem, f, q};
        @(negedge clock);
        conv_done = 1'b0;
        conv_result = ~conv_result;
        if (!cfg[6]) begin
            sel = ~sel;
            if (!rem) loc = v[15:8];
            else if (f == 2'b00) begin
                rlo = v[7:0];
                if (!lock) rhi = v[15:8];
            end
        end
        check({7'h00, conv_remote_sel}, {7'h00, sel});
    endtask : conv

    task automatic pin(input logic e);
        repeat (2) @(negedge clock);
        check({7'h00, shared_pin_n}, {7'h00, e});
    endtask : pin
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 32'he85c;
        {fail_count, compares} = '0;
        {ce, sys_rst, conv_done, conv_result, limits} = {3'b110, 14'h0000, 32'hFF00FF00};
        {cfg, loc, rhi, rlo, lock, sel} = '0;
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        check({7'h00, conv_run}, 8'h01);
        exp_q.push_back(8'h00);
        i_host.read_req();
        foreach (regs[k]) rd(regs[k], 8'h00);
        wr(8'h00, 8'h55);
        wr(8'h03, 8'hFF);
        rd(8'h00, 8'h00);
        rd(8'h03, 8'h00);
        wr(8'h09, 8'hE4);
        rd(8'h03, 8'hE4);
        check({7'h00, conv_run}, 8'h00);
        wr(8'h09, 8'h00);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            if (i == 12) begin
                wr(8'h09, 8'h04);
                rd(8'h00, mdl(8'h00));
            end
            tq = cfg[2] ? {9'(r[7:0]) - 9'd64, r[9:8]} : r[10:0];
            conv(r[11], 2'b00, tq);
            rd(8'h10, mdl(8'h10));
            rd(8'h01, mdl(8'h01));
            rd(8'h00, mdl(8'h00));
        end
        for (int e = 0; e < 2; e++) begin
            wr(8'h09, e ? 8'h04 : 8'h00);
            for (int j = 0; j < 4; j++) begin
                conv(1'b0, 2'b00, 11'(temps[j] * 4));
                rd(8'h00, ftab[e * 4 + j]);
                conv(1'b1, 2'b00, 11'(temps[j] * 4));
                rd(8'h10, 8'h00);
                rd(8'h01, ftab[e * 4 + j]);
            end
        end
        wr(8'h09, 8'h00);
        conv(1'b1, 2'b00, {9'd30, 2'b10});
        rd(8'h10, 8'h80);
        conv(1'b1, 2'b00, {9'd40, 2'b11});
        rd(8'h01, 8'h1E);
        rd(8'h10, 8'hC0);
        rd(8'h01, 8'h1E);
        conv(1'b1, 2'b00, {9'd41, 2'b00});
        rd(8'h01, 8'h29);
        conv(1'b0, 2'b00, {9'd50, 2'b00});
        conv(1'b1, 2'b10, 11'h7FC);
        rd(8'h10, mdl(8'h10));
        rd(8'h01, mdl(8'h01));
        pin(1'b0);
        conv(1'b1, 2'b01, 11'h3FC);
        pin(1'b0);
        conv(1'b1, 2'b00, {9'd25, 2'b01});
        pin(1'b1);
        foreach (atab[k]) begin
            wr(8'h09, atab[k][47:40]);
            // Limits reprogrammed by the host after any range change
            limits = atab[k][39:8];
            pin(atab[k][0]);
        end
        // Frozen clock enable must hold the pin at its old level
        ce = 1'b0;
        limits = 32'hFF00FF00;
        pin(1'b0);
        ce = 1'b1;
        wr(8'h09, 8'h40);
        check({7'h00, conv_run}, 8'h00);
        conv(1'b0, 2'b00, {9'd100, 2'b00});
        rd(8'h00, 8'h32);
        limits = 32'h3100FF00;
        pin(1'b0);
        wr(8'h09, 8'h00);
        check({7'h00, conv_run}, 8'h01);
        check(8'(exp_q.size()), 8'h00);
        results();
    end

    // Generous bound; the sequence needs about 820 cycles
    initial begin
        repeat (50000) @(posedge clock);
        fail_count++;
        results();
    end
endmodule : tb_top
